// ---- verilog/wsar_pkg.sv ----
package wsar_pkg;
  // ==========================================================
  // storage word layout
  localparam int DATA_W = 48;
  localparam int WORD_W = 51;
  localparam int ADDR_W = 15;
  localparam int LOW_LSB = 0;
  localparam int LOW_W = 15;
  localparam int HIGH_LSB = 24;
  localparam int HIGH_W = 15;
  localparam int LOW_CHK_BIT = 48;
  localparam int HIGH_CHK_BIT = 49;
  localparam int OP_CHK_BIT = 50;
  localparam int SECTION_BIT = 14;
  localparam int NUM_INDEX = 6;
  localparam int IDX_SEL_W = 3;

  // ==========================================================
  // fixed return-jump targets
  localparam logic [14:0] RESTART_ADDR = 15'h0000;
  localparam logic [14:0] CAT1_ADDR = 15'h0007;
  localparam logic [14:0] CAT2_ADDR = 15'h0018;
  localparam logic [14:0] CAT3_ADDR = 15'h001B;
  localparam logic [14:0] PC_RESET = 15'h0000;
  localparam logic [14:0] PC_STEP = 15'h0001;

  // ==========================================================
  // operation codes for the arithmetic registers
  typedef enum logic [3:0] {
    WSAR_OP_NONE, WSAR_OP_LOAD_A, WSAR_OP_LOAD_Q, WSAR_OP_ADD, WSAR_OP_SUB,
    WSAR_OP_AND, WSAR_OP_SHL_A, WSAR_OP_SHR_A, WSAR_OP_SHL_Q, WSAR_OP_SHR_Q,
    WSAR_OP_SHL_AQ, WSAR_OP_SHR_AQ, WSAR_OP_SHL_QA, WSAR_OP_SHR_QA, WSAR_OP_LOAD_IDX
  } wsar_op_t;

  // program counter commands
  typedef enum logic [2:0] {
    WSAR_PC_HOLD, WSAR_PC_STEP, WSAR_PC_JUMP, WSAR_PC_RJUMP, WSAR_PC_INTR, WSAR_PC_RESTART
  } wsar_pc_t;

  // read portion selection: bit0 low, bit1 high, bit2 function
  localparam logic [2:0] PORT_ALL = 3'h7;
endpackage : wsar_pkg

// ---- verilog/wsar_ones_add.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// one's complement adder with end-around carry
module wsar_ones_add #(
  parameter int W = 15
) (
  input wire logic [W-1:0] a_in,
  input wire logic [W-1:0] b_in,
  output logic [W-1:0] sum_out
);
  logic [W:0] raw;
  logic [W:0] wrapped;
  // carry out folds back in, so modulus is 2^W-1
  always_comb begin
    raw = {1'b0, a_in} + {1'b0, b_in};
    wrapped = {1'b0, raw[W-1:0]} + {{W{1'b0}}, raw[W]};
    sum_out = wrapped[W-1:0];
  end
endmodule : wsar_ones_add
`default_nettype wire

// ---- verilog/wsar_parity.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// odd parity generator and checker for one portion
module wsar_parity #(
  parameter int W = 15
) (
  input wire logic [W-1:0] data_in,
  input wire logic chk_in,
  output logic gen_out,
  output logic bad_out
);
  // odd parity: data plus check bit has an odd count of ones
  always_comb begin
    gen_out = ~(^data_in);
    bad_out = ~(^{data_in, chk_in});
  end
endmodule : wsar_parity
`default_nettype wire

// ---- verilog/wsar_core.sv ----
`timescale 1ns/10ps
`default_nettype none
module wsar_core
  import wsar_pkg::*;
#(
  parameter bit HALF_SIZE = 1'b0,
  parameter logic [2:0] CAT_PRESENT = 3'h7
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire wsar_pkg::wsar_op_t op_in,
  input wire logic [wsar_pkg::DATA_W-1:0] operand_in,
  input wire logic [wsar_pkg::IDX_SEL_W-1:0] idx_sel_in,
  input wire wsar_pkg::wsar_pc_t pc_cmd_in,
  input wire logic jump_cond_in,
  input wire logic [1:0] intr_cat_in,
  input wire logic [wsar_pkg::ADDR_W-1:0] base_addr_in,
  input wire logic [wsar_pkg::IDX_SEL_W-1:0] base_idx_in,
  input wire logic mem_wr_in,
  input wire logic [wsar_pkg::DATA_W-1:0] mem_wdata_in,
  input wire logic mem_rd_valid_in,
  input wire logic [2:0] mem_rd_part_in,
  input wire logic [wsar_pkg::WORD_W-1:0] mem_rdata_in,
  output logic [wsar_pkg::WORD_W-1:0] mem_wdata_out,
  output logic mem_wr_out,
  output logic [wsar_pkg::ADDR_W-1:0] mod_addr_out,
  output logic [wsar_pkg::ADDR_W-1:0] pc_out,
  output logic [wsar_pkg::ADDR_W-1:0] saved_pc_out,
  output logic saved_pc_valid_out,
  output logic [wsar_pkg::DATA_W-1:0] arith_a_out,
  output logic [wsar_pkg::DATA_W-1:0] arith_q_out,
  output logic a_negative_out,
  output logic a_zero_out,
  output logic [2:0] parity_err_out,
  output logic [wsar_pkg::DATA_W-1:0] rd_data_out,
  output logic rd_valid_out
);
  import wsar_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic [DATA_W-1:0] a;
    logic [DATA_W-1:0] q;
    logic [ADDR_W-1:0] pc;
    logic [ADDR_W-1:0] saved_pc;
    logic saved_v;
    logic [NUM_INDEX*ADDR_W-1:0] idx;
    logic [ADDR_W-1:0] mod_addr;
    logic [WORD_W-1:0] wdata;
    logic wr;
    logic [2:0] perr;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    logic az;
  } wsar_state_t;

  wsar_state_t s_q;
  wsar_state_t s_d;

  // ==========================================================
  // portion views of the incoming and outgoing words
  logic [LOW_W-1:0] rd_low;
  logic [HIGH_W-1:0] rd_high;
  logic [DATA_W-LOW_W-HIGH_W-1:0] rd_op;
  logic [LOW_W-1:0] wr_low;
  logic [HIGH_W-1:0] wr_high;
  logic [DATA_W-LOW_W-HIGH_W-1:0] wr_op;
  logic gen_low, gen_high, gen_op;
  logic bad_low, bad_high, bad_op;

  // function portion is everything outside the two address fields
  assign rd_low = mem_rdata_in[LOW_LSB +: LOW_W];
  assign rd_high = mem_rdata_in[HIGH_LSB +: HIGH_W];
  assign rd_op = {mem_rdata_in[DATA_W-1:HIGH_LSB+HIGH_W], mem_rdata_in[HIGH_LSB-1:LOW_LSB+LOW_W]};
  assign wr_low = mem_wdata_in[LOW_LSB +: LOW_W];
  assign wr_high = mem_wdata_in[HIGH_LSB +: HIGH_W];
  assign wr_op = {mem_wdata_in[DATA_W-1:HIGH_LSB+HIGH_W], mem_wdata_in[HIGH_LSB-1:LOW_LSB+LOW_W]};

  wsar_parity #(.W(LOW_W)) u_par_low (
    .data_in(rd_low), .chk_in(mem_rdata_in[LOW_CHK_BIT]), .gen_out(), .bad_out(bad_low)
  );
  wsar_parity #(.W(HIGH_W)) u_par_high (
    .data_in(rd_high), .chk_in(mem_rdata_in[HIGH_CHK_BIT]), .gen_out(), .bad_out(bad_high)
  );
  wsar_parity #(.W(DATA_W-LOW_W-HIGH_W)) u_par_op (
    .data_in(rd_op), .chk_in(mem_rdata_in[OP_CHK_BIT]), .gen_out(), .bad_out(bad_op)
  );
  wsar_parity #(.W(LOW_W)) u_gen_low (
    .data_in(wr_low), .chk_in(1'b0), .gen_out(gen_low), .bad_out()
  );
  wsar_parity #(.W(HIGH_W)) u_gen_high (
    .data_in(wr_high), .chk_in(1'b0), .gen_out(gen_high), .bad_out()
  );
  wsar_parity #(.W(DATA_W-LOW_W-HIGH_W)) u_gen_op (
    .data_in(wr_op), .chk_in(1'b0), .gen_out(gen_op), .bad_out()
  );

  // ==========================================================
  // index modification
  logic [ADDR_W-1:0] idx_val;
  logic [ADDR_W-1:0] idx_sum;
  logic [ADDR_W-1:0] sec_addr;

  // designator zero and out-of-range codes select no index
  always_comb begin
    idx_val = '0;
    if (base_idx_in != '0 && base_idx_in <= IDX_SEL_W'(NUM_INDEX)) begin
      idx_val = s_q.idx[(32'(base_idx_in) - 1) * ADDR_W +: ADDR_W];
    end
  end

  // end-around carry means all ones appears whenever the inputs sum to all ones, e.g. a value plus its complement
  wsar_ones_add #(.W(ADDR_W)) u_idx_add (
    .a_in(base_addr_in), .b_in(idx_val), .sum_out(idx_sum)
  );

  // half-size storage has one section, so the select bit is held low
  always_comb begin
    sec_addr = (base_idx_in == '0) ? base_addr_in : idx_sum;
    if (HALF_SIZE) begin
      sec_addr[SECTION_BIT] = 1'b0;
    end
  end

  // ==========================================================
  // arithmetic unit, subtractive form: a + b computed as a - (~b)
  logic [DATA_W:0] sub_raw;
  logic [DATA_W:0] sub_fix;
  logic [DATA_W-1:0] addend;
  logic [DATA_W-1:0] arith_res;

  // subtractive adder gives +0 for zero sums; only -0 + -0 stays -0
  always_comb begin
    addend = (op_in == WSAR_OP_SUB) ? operand_in : ~operand_in;
    sub_raw = {1'b0, s_q.a} - {1'b0, addend};
    // end-around borrow keeps the modulus at 2^48-1
    sub_fix = {1'b0, sub_raw[DATA_W-1:0]} - {{DATA_W{1'b0}}, sub_raw[DATA_W]};
    arith_res = sub_fix[DATA_W-1:0];
  end

  // ==========================================================
  // next state
  logic [ADDR_W-1:0] cat_target;
  logic cat_ok;

  always_comb begin
    case (intr_cat_in)
      2'h1: cat_target = CAT2_ADDR;
      2'h2: cat_target = CAT3_ADDR;
      default: cat_target = CAT1_ADDR;
    endcase
    cat_ok = CAT_PRESENT[intr_cat_in[1] ? 2 : (intr_cat_in[0] ? 1 : 0)];
  end

  always_comb begin
    s_d = s_q;
    s_d.saved_v = 1'b0;
    s_d.rvalid = 1'b0;
    s_d.mod_addr = sec_addr;
    // arithmetic registers
    case (op_in)
      WSAR_OP_LOAD_A: s_d.a = operand_in;
      WSAR_OP_LOAD_Q: s_d.q = operand_in;
      WSAR_OP_ADD, WSAR_OP_SUB: s_d.a = arith_res;
      WSAR_OP_AND: s_d.a = s_q.a & operand_in;
      WSAR_OP_SHL_A: s_d.a = {s_q.a[DATA_W-2:0], s_q.a[DATA_W-1]};
      WSAR_OP_SHR_A: s_d.a = {s_q.a[DATA_W-1], s_q.a[DATA_W-1:1]};
      WSAR_OP_SHL_Q: s_d.q = {s_q.q[DATA_W-2:0], s_q.q[DATA_W-1]};
      WSAR_OP_SHR_Q: s_d.q = {s_q.q[DATA_W-1], s_q.q[DATA_W-1:1]};
      WSAR_OP_SHL_AQ: {s_d.a, s_d.q} = {s_q.a[DATA_W-2:0], s_q.q, s_q.a[DATA_W-1]};
      WSAR_OP_SHR_AQ: {s_d.a, s_d.q} = {s_q.a[DATA_W-1], s_q.a, s_q.q[DATA_W-1:1]};
      WSAR_OP_SHL_QA: {s_d.q, s_d.a} = {s_q.q[DATA_W-2:0], s_q.a, s_q.q[DATA_W-1]};
      WSAR_OP_SHR_QA: {s_d.q, s_d.a} = {s_q.q[DATA_W-1], s_q.q, s_q.a[DATA_W-1:1]};
      WSAR_OP_LOAD_IDX: begin
        if (idx_sel_in != '0 && idx_sel_in <= IDX_SEL_W'(NUM_INDEX)) begin
          s_d.idx[(32'(idx_sel_in) - 1) * ADDR_W +: ADDR_W] = operand_in[ADDR_W-1:0];
        end
      end
      default: ;
    endcase
    // program counter, modulo 2^15 by natural wrap
    case (pc_cmd_in)
      WSAR_PC_STEP: s_d.pc = s_q.pc + PC_STEP;
      WSAR_PC_JUMP: begin
        // a conditional jump is steered by the external jump_cond_in input
        if (jump_cond_in) begin
          s_d.pc = sec_addr;
        end else begin
          s_d.pc = s_q.pc + PC_STEP;
        end
      end
      WSAR_PC_RJUMP: begin
        if (jump_cond_in) begin
          s_d.saved_pc = s_q.pc;
          s_d.saved_v = 1'b1;
          s_d.pc = sec_addr;
        end else begin
          s_d.pc = s_q.pc + PC_STEP;
        end
      end
      WSAR_PC_INTR: begin
        if (cat_ok) begin
          s_d.saved_pc = s_q.pc;
          s_d.saved_v = 1'b1;
          s_d.pc = cat_target;
        end
      end
      WSAR_PC_RESTART: begin
        s_d.saved_pc = s_q.pc;
        s_d.saved_v = 1'b1;
        s_d.pc = RESTART_ADDR;
      end
      default: ;
    endcase
    // write path appends one check bit per portion
    s_d.wr = mem_wr_in;
    s_d.wdata = {gen_op, gen_high, gen_low, mem_wdata_in};
    // read check covers only the portions actually fetched
    s_d.perr = '0;
    if (mem_rd_valid_in) begin
      s_d.rdata = mem_rdata_in[DATA_W-1:0];
      s_d.rvalid = 1'b1;
      s_d.perr = {bad_op, bad_high, bad_low} & mem_rd_part_in;
    end
    // zero flag registered so the output comes straight from a flip-flop
    s_d.az = (s_d.a == '0);
  end

  // ==========================================================
  // register the whole state
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
      s_q.az <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs straight from flip-flops
  assign mem_wdata_out = s_q.wdata;
  assign mem_wr_out = s_q.wr;
  assign mod_addr_out = s_q.mod_addr;
  assign pc_out = s_q.pc;
  assign saved_pc_out = s_q.saved_pc;
  assign saved_pc_valid_out = s_q.saved_v;
  assign arith_a_out = s_q.a;
  assign arith_q_out = s_q.q;
  assign a_negative_out = s_q.a[DATA_W-1];
  assign a_zero_out = s_q.az;
  assign parity_err_out = s_q.perr;
  assign rd_data_out = s_q.rdata;
  assign rd_valid_out = s_q.rvalid;
endmodule : wsar_core
`default_nettype wire

// ---- test/wsar_core_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// port checker for the core
module wsar_core_chk
  import wsar_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire wsar_pkg::wsar_op_t op_in,
  input wire logic [47:0] operand_in,
  input wire logic a_zero_out,
  input wire wsar_pkg::wsar_pc_t pc_cmd_in,
  input wire logic jump_cond_in,
  input wire logic [14:0] base_addr_in,
  input wire logic [2:0] base_idx_in,
  input wire logic mem_wr_in,
  input wire logic [47:0] mem_wdata_in,
  input wire logic mem_rd_valid_in,
  input wire logic [2:0] mem_rd_part_in,
  input wire logic [50:0] mem_rdata_in,
  input wire logic [50:0] mem_wdata_out,
  input wire logic mem_wr_out,
  input wire logic [14:0] mod_addr_out,
  input wire logic [14:0] pc_out,
  input wire logic [14:0] saved_pc_out,
  input wire logic saved_pc_valid_out,
  input wire logic [47:0] arith_a_out,
  input wire logic a_negative_out,
  input wire logic [2:0] parity_err_out,
  input wire logic rd_valid_out
);
  // portions failing odd parity: {func, high, low}
  function automatic logic [2:0] bad3(input logic [50:0] v);
    return {~^{v[50], v[47:39], v[23:15]}, ~^{v[49], v[38:24]}, ~^{v[48], v[14:0]}};
  endfunction : bad3
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  AST_PC_STEP: assert property (pc_cmd_in == WSAR_PC_STEP |=> pc_out == $past(pc_out) + PC_STEP)
    else $error("pc step wrong");
  AST_PC_JUMP: assert property (pc_cmd_in == WSAR_PC_JUMP && jump_cond_in && base_idx_in == 3'h0
    |=> pc_out == $past(base_addr_in)) else $error("jump target wrong");
  AST_PC_SAVE: assert property (pc_cmd_in == WSAR_PC_RJUMP && jump_cond_in
    |=> saved_pc_valid_out && saved_pc_out == $past(pc_out)) else $error("return pc wrong");
  AST_RESTART: assert property (pc_cmd_in == WSAR_PC_RESTART |=> pc_out == RESTART_ADDR) else $error("restart");
  AST_WR_WORD: assert property (mem_wr_in |=> mem_wr_out && bad3(mem_wdata_out) == 3'h0
    && mem_wdata_out[47:0] == $past(mem_wdata_in)) else $error("stored word wrong");
  AST_RD_CHECK: assert property (mem_rd_valid_in |=> rd_valid_out
    && parity_err_out == (bad3($past(mem_rdata_in)) & $past(mem_rd_part_in))) else $error("parity flag wrong");
  AST_IDX0: assert property (base_idx_in == 3'h0 |=> mod_addr_out == $past(base_addr_in)) else $error("addr");
  AST_SIGN: assert property (op_in == WSAR_OP_LOAD_A |=> a_negative_out == $past(operand_in[47]))
    else $error("sign flag wrong");
  AST_ZERO: assert property (a_zero_out == (arith_a_out == 48'h0)) else $error("zero flag wrong");
endmodule : wsar_core_chk
`default_nettype wire

// ---- test/wsar_store_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// storage array on the far side
module wsar_store_model
  import wsar_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic wr_in,
  input wire logic [wsar_pkg::WORD_W-1:0] wdata_in,
  input wire logic [wsar_pkg::ADDR_W-1:0] addr_in,
  input wire logic rd_go_in,
  input wire logic [wsar_pkg::WORD_W-1:0] flip_in,
  output logic rd_valid_out,
  output logic [wsar_pkg::WORD_W-1:0] rdata_out
);
  logic [50:0] mem_q [int];
  // idle bus toggles so stale data never looks valid
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_valid_out <= 1'h0;
      rdata_out <= '0;
    end else begin
      if (wr_in) mem_q[int'(addr_in)] = wdata_in;
      rd_valid_out <= rd_go_in;
      rdata_out <= rd_go_in ? mem_q[int'(addr_in)] ^ flip_in : ~rdata_out;
    end
  end
endmodule : wsar_store_model
`default_nettype wire

// ---- test/wsar_core_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin err_total++; $display("mismatch %s expected %h seen %h", n, e, s); end end
// ==========================================================
// bench top
module wsar_core_tb_top;
  import wsar_pkg::*;
  typedef struct {int due; int k; logic [50:0] v;} wsar_note_t;
  logic clk_in = 1'h0, rst_n_in = 1'h0, jump_cond_in = 1'h0, mem_wr_in = 1'h0, rd_go = 1'h0;
  wsar_op_t op_in = WSAR_OP_NONE;
  wsar_pc_t pc_cmd_in = WSAR_PC_HOLD;
  logic [47:0] operand_in = 48'h0, mem_wdata_in = 48'h0, arith_a_out, arith_q_out, rd_data_out;
  logic [2:0] idx_sel_in = 3'h0, base_idx_in = 3'h0, mem_rd_part_in = 3'h7, parity_err_out;
  logic [1:0] intr_cat_in = 2'h0;
  logic [14:0] base_addr_in = 15'h0, mod_addr_out, pc_out, saved_pc_out;
  logic [50:0] flip = 51'h0, w, mem_rdata_in, mem_wdata_out;
  logic mem_rd_valid_in, mem_wr_out, saved_pc_valid_out, a_negative_out, a_zero_out, rd_valid_out;
  logic [31:0] seed = 32'h0000000B;
  int cyc = 0, err_total = 0, total_checks = 0;
  wsar_note_t notes[$];
  wsar_note_t nt;
  string nm[10] = '{"pc", "saved_pc", "saved_vld", "acc_a", "acc_q", "mod_addr", "par_err", "rd_data", "word", "a_zero"};
  wsar_core dut (.*);
  wsar_store_model u_store (.clk_in(clk_in), .rst_n_in(rst_n_in), .wr_in(mem_wr_out), .wdata_in(mem_wdata_out),
    .addr_in(mod_addr_out), .rd_go_in(rd_go), .flip_in(flip), .rd_valid_out(mem_rd_valid_in), .rdata_out(mem_rdata_in));
  // clock and cycle count
  initial forever #2 clk_in = ~clk_in;
  always @(posedge clk_in) cyc <= cyc + 1;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [50:0] obs(input int k);
    case (k)
      0: return 51'(pc_out);
      1: return 51'(saved_pc_out);
      2: return 51'(saved_pc_valid_out);
      3: return 51'(arith_a_out);
      4: return 51'(arith_q_out);
      5: return 51'(mod_addr_out);
      6: return 51'(parity_err_out);
      7: return 51'(rd_data_out);
      8: return mem_wdata_out;
      default: return 51'(a_zero_out);
    endcase
  endfunction : obs
  // end-around carry; only minus zero plus minus zero stays all ones
  function automatic logic [47:0] add48(input logic [47:0] a, input logic [47:0] b);
    logic [48:0] s;
    s = {1'h0, a} + {1'h0, b};
    s = {1'h0, s[47:0]} + 49'(s[48]);
    if (&s[47:0] && !(&a && &b)) s = '0;
    return s[47:0];
  endfunction : add48
  function automatic logic [14:0] add15(input logic [14:0] a, input logic [14:0] b);
    logic [15:0] s;
    s = {1'h0, a} + {1'h0, b};
    return s[14:0] + 15'(s[15]);
  endfunction : add15
  function automatic logic [50:0] wrd(input logic [47:0] d);
    return {~^{d[47:39], d[23:15]}, ~^d[38:24], ~^d[14:0], d};
  endfunction : wrd
  task automatic note(input int d, input int k, input logic [50:0] v);
    notes.push_back('{cyc + d, k, v});
  endtask : note
  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask : tick
  task automatic pcs(input wsar_pc_t c, input logic [14:0] b, input logic [14:0] e);
    pc_cmd_in = c;
    base_addr_in = b;
    note(1, 0, 51'(e));
    tick();
  endtask : pcs
  // read back through the array, part held for the valid edge
  task automatic rd(input logic [50:0] f, input logic [2:0] p, input logic [2:0] e);
    rd_go = 1'h1;
    flip = f;
    note(2, 7, 51'(w[47:0] ^ f[47:0]));
    note(2, 6, 51'(e));
    tick();
    rd_go = 1'h0;
    mem_rd_part_in = p;
    tick();
  endtask : rd
  task automatic stop_test();
    if (err_total == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  // result watcher
  always @(posedge clk_in) begin
    #2;
    while (notes.size() > 0 && notes[0].due <= cyc) begin
      nt = notes.pop_front();
      `CHK(nm[nt.k], nt.v, obs(nt.k))
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (2) tick();
    rst_n_in = 1'h1;
    note(1, 9, 51'h1);
    jump_cond_in = 1'h1;
    pcs(WSAR_PC_JUMP, 15'h7FFE, 15'h7FFE);
    pcs(WSAR_PC_STEP, 15'h0000, 15'h7FFF);
    pcs(WSAR_PC_STEP, 15'h0000, 15'h0000);
    pcs(WSAR_PC_JUMP, 15'h0055, 15'h0055);
    note(1, 1, 51'h55);
    note(1, 2, 51'h1);
    pcs(WSAR_PC_RJUMP, 15'h0200, 15'h0200);
    jump_cond_in = 1'h0;
    pcs(WSAR_PC_JUMP, 15'h1234, 15'h0201);
    jump_cond_in = 1'h1;
    for (int i = 0; i < 3; i++) begin
      intr_cat_in = 2'(i);
      pcs(WSAR_PC_INTR, 15'h0000, i == 0 ? CAT1_ADDR : i == 1 ? CAT2_ADDR : CAT3_ADDR);
    end
    pcs(WSAR_PC_RESTART, 15'h0000, RESTART_ADDR);
    pc_cmd_in = WSAR_PC_HOLD;
    for (int i = 1; i < 7; i++) begin
      idx_sel_in = 3'(i);
      operand_in = 48'(rnd());
      op_in = WSAR_OP_LOAD_IDX;
      tick();
      op_in = WSAR_OP_NONE;
      base_idx_in = 3'(i);
      base_addr_in = 15'(rnd());
      w = 51'(add15(base_addr_in, operand_in[14:0]));
      if (~&w[14:0]) note(1, 5, w);
      tick();
    end
    base_idx_in = 3'h0;
    note(1, 5, 51'(base_addr_in));
    tick();
    for (int i = 0; i < 4; i++) begin
      w[47:0] = i == 0 ? '1 : 48'({rnd(), rnd()});
      operand_in = w[47:0];
      op_in = WSAR_OP_LOAD_A;
      note(1, 3, 51'(w[47:0]));
      tick();
      operand_in = i == 1 ? ~w[47:0] : i == 0 ? '1 : 48'({rnd(), rnd()});
      op_in = WSAR_OP_ADD;
      note(1, 3, 51'(add48(w[47:0], operand_in)));
      if (i == 1) note(1, 9, 51'h1);
      tick();
    end
    operand_in = 48'(rnd());
    op_in = WSAR_OP_LOAD_Q;
    note(1, 4, 51'(operand_in));
    tick();
    op_in = WSAR_OP_NONE;
    base_addr_in = 15'(rnd());
    w[47:0] = 48'({rnd(), rnd()});
    mem_wdata_in = w[47:0];
    mem_wr_in = 1'h1;
    note(1, 8, wrd(w[47:0]));
    tick();
    mem_wr_in = 1'h0;
    tick();
    rd(51'h0, 3'h7, 3'h0);
    rd(51'h2000000000000, 3'h7, 3'h2);
    rd(51'h20, 3'h6, 3'h0);
    rd(51'h20, 3'h1, 3'h1);
    pcs(WSAR_PC_JUMP, 15'h0123, 15'h0123);
    pc_cmd_in = WSAR_PC_HOLD;
    tick();
    rst_n_in = 1'h0;
    tick();
    rst_n_in = 1'h1;
    note(1, 0, 51'h0);
    note(1, 3, 51'h0);
    note(1, 9, 51'h1);
    tick();
    for (int i = 0; i < 20 && notes.size() > 0; i++) tick();
    if (notes.size() > 0) err_total++;
    stop_test();
  end
endmodule : wsar_core_tb_top
bind wsar_core wsar_core_chk u_chk (.*);
`default_nettype wire
